// ---- verilog/tcp_timer_compare.sv ----
// The APB slave port and the address map are this design's own decisions.
`timescale 1ns/1ps
// Summary of operation
// - Match sets compare flag, drives stored level
// - Compare pin latches low during reset
// - Compare irq needs enable and clear mask
// - Status read then low byte access clears
// - High byte write inhibits until low write
// - Pin enable clear keeps pin untouched
// - Divide-by-2 matches value, others value plus one
// - Force copies level, no flag, no irq
// - Force ignored in one-pulse or PWM
// - One-pulse select enables pulse on trigger
// - Trigger: counter FFFC, level2, flag, capture FFFD
// - Trigger capture flag interrupts when enabled
// - Capture flag cleared likewise via low byte
// - One-pulse compare 1 match drives level1
// - One-pulse: no flag1; compare 2 no waveform
// - PWM select overrides one-pulse select
// - One-pulse trigger pin restarts, captures FFFD not the count
// - PWM: compare1 gives level1, compare2 level2
// - PWM compare 2 match reloads counter FFFC
// - PWM sets no compare flags
// - PWM compare 2 match sets capture flag 1
// - PWM disconnects trigger pin, capture 2 works
// - Compare values reset to 8000h only
// - Both select bits high picks external clock
module tcp_timer_compare (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic cpuIrqMask,
   input wire logic triggerInputPin,
   input wire logic captureTwoPin,
   input wire logic extClockPin,
   output logic [1:0] compareOutputPin,
   output logic [1:0] compareOutputEn,
   output logic timerIrq
);
   import tcp_pkg::*;

   logic [7:0] ctrlOne_q, ctrlTwo_q;
   logic [15:0] counter_q;
   logic [15:0] cmpVal_q [0:1];
   logic [15:0] capVal_q [0:1];
   logic [1:0] cmpFlag_q, capFlag_q, cmpArm_q, capArm_q, cmpInhibit_q, pinLevel_q;
   logic [1:0] pinSync1_q, pinSync2_q, pinPrev_q, pinEdge, edgeSel;
   logic counterMoved_q, pready_q, pslverr_q, irq_q;
   logic [31:0] prdata_q;
   tcp_mode_type mode_q, mode_d;
   logic tick;

   ////////////////////////////////////////////////////////////////////////////
   // Timer clock source
   tcp_timer_tick uTick (
      .clk(clk),
      .rst_n(rst_n),
      .timerClockSelect(ctrlTwo_q[BIT_CLK_SEL_HI:BIT_CLK_SEL_LO]),
      .extEdgeSel(ctrlTwo_q[BIT_EXT_EDGE]),
      .extClockPin(extClockPin),
      .tick(tick)
   );

   ////////////////////////////////////////////////////////////////////////////
   // APB decode; answer comes one cycle into the access phase
   logic setupSeen, access, wrAccess, rdAccess, addrHit;
   logic [1:0] cmpHiWr, cmpLoWr, cmpLoAcc, capLoAcc;
   logic statusRd, cntLoWr;
   logic [7:0] statusByte, readByte;
   assign setupSeen = psel & penable & ~pready_q;
   assign access = psel & penable & pready_q;
   assign wrAccess = access & pwrite;
   assign rdAccess = access & ~pwrite;
   assign statusRd = rdAccess & (paddr == ADDR_STATUS);
   assign cmpHiWr = {wrAccess & (paddr == ADDR_CMP2_HI), wrAccess & (paddr == ADDR_CMP1_HI)};
   assign cmpLoWr = {wrAccess & (paddr == ADDR_CMP2_LO), wrAccess & (paddr == ADDR_CMP1_LO)};
   assign cmpLoAcc = {access & (paddr == ADDR_CMP2_LO), access & (paddr == ADDR_CMP1_LO)};
   assign capLoAcc = {access & (paddr == ADDR_CAP2_LO), access & (paddr == ADDR_CAP1_LO)};
   assign cntLoWr = wrAccess & (paddr == ADDR_CNT_LO);
   assign statusByte = {capFlag_q[0], cmpFlag_q[0], 1'b0, capFlag_q[1], cmpFlag_q[1], 3'h0};
   assign addrHit = (paddr == ADDR_CTRL_ONE) | (paddr == ADDR_CTRL_TWO) | (paddr == ADDR_STATUS) |
                    (paddr == ADDR_CAP1_HI) | (paddr == ADDR_CAP1_LO) | (paddr == ADDR_CMP1_HI) |
                    (paddr == ADDR_CMP1_LO) | (paddr == ADDR_CNT_HI) | (paddr == ADDR_CNT_LO) |
                    (paddr == ADDR_CAP2_HI) | (paddr == ADDR_CAP2_LO) | (paddr == ADDR_CMP2_HI) |
                    (paddr == ADDR_CMP2_LO);
   // Read mux; unmapped offsets read zero
   assign readByte = (paddr == ADDR_CTRL_ONE) ? ctrlOne_q :
                     (paddr == ADDR_CTRL_TWO) ? ctrlTwo_q :
                     (paddr == ADDR_STATUS) ? statusByte :
                     (paddr == ADDR_CAP1_HI) ? capVal_q[0][15:8] :
                     (paddr == ADDR_CAP1_LO) ? capVal_q[0][7:0] :
                     (paddr == ADDR_CMP1_HI) ? cmpVal_q[0][15:8] :
                     (paddr == ADDR_CMP1_LO) ? cmpVal_q[0][7:0] :
                     (paddr == ADDR_CNT_HI) ? counter_q[15:8] :
                     (paddr == ADDR_CNT_LO) ? counter_q[7:0] :
                     (paddr == ADDR_CAP2_HI) ? capVal_q[1][15:8] :
                     (paddr == ADDR_CAP2_LO) ? capVal_q[1][7:0] :
                     (paddr == ADDR_CMP2_HI) ? cmpVal_q[1][15:8] :
                     (paddr == ADDR_CMP2_LO) ? cmpVal_q[1][7:0] : 8'h00;

   // Bus answer flops
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q <= 32'h0;
      end else begin
         pready_q <= setupSeen;
         pslverr_q <= setupSeen & ~addrHit;
         prdata_q <= setupSeen ? {24'h0, readByte} : prdata_q;
      end
   end

   // Control registers, software owned
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         ctrlOne_q <= CTRL_RESET;
         ctrlTwo_q <= CTRL_RESET;
      end else begin
         if (wrAccess & (paddr == ADDR_CTRL_ONE)) ctrlOne_q <= pwdata[7:0];
         if (wrAccess & (paddr == ADDR_CTRL_TWO)) ctrlTwo_q <= pwdata[7:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Mode select, PWM wins over one-pulse; taken only on a timer tick
   assign mode_d = ctrlTwo_q[BIT_PWM] ? MODE_PWM :
                   ctrlTwo_q[BIT_ONE_PULSE] ? MODE_ONE_PULSE : MODE_NORMAL;

   always_ff @(posedge clk) begin
      if (!rst_n) mode_q <= MODE_NORMAL;
      else if (tick) mode_q <= mode_d;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Capture pins: two flops, then the selected edge
   assign edgeSel = {ctrlTwo_q[BIT_EDGE2], ctrlOne_q[BIT_EDGE1]};
   generate
      for (genvar ch = 0; ch < 2; ch++) begin : gPin
         always_ff @(posedge clk) begin
            if (!rst_n) begin
               pinSync1_q[ch] <= 1'b0;
               pinSync2_q[ch] <= 1'b0;
               pinPrev_q[ch] <= 1'b0;
            end else begin
               pinSync1_q[ch] <= (ch == 0) ? triggerInputPin : captureTwoPin;
               pinSync2_q[ch] <= pinSync1_q[ch];
               pinPrev_q[ch] <= pinSync2_q[ch];
            end
         end
         assign pinEdge[ch] = edgeSel[ch] ? (pinSync2_q[ch] & ~pinPrev_q[ch]) : (~pinSync2_q[ch] & pinPrev_q[ch]);
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   // Compare: evaluated once per new counter value
   logic div2Clk;
   logic [15:0] cmpTarget [0:1];
   logic [1:0] cmpMatch, cmpSet, capSet, cmpClr, capClr;
   logic trigEvent, capOneNormal, pwmReload, cntReload;
   assign div2Clk = ctrlTwo_q[BIT_CLK_SEL_HI:BIT_CLK_SEL_LO] == CLK_DIV2;
   assign cmpTarget[0] = div2Clk ? cmpVal_q[0] : cmpVal_q[0] + 16'h1;
   assign cmpTarget[1] = div2Clk ? cmpVal_q[1] : cmpVal_q[1] + 16'h1;
   assign cmpMatch[0] = counterMoved_q & ~cmpInhibit_q[0] & (counter_q == cmpTarget[0]);
   assign cmpMatch[1] = counterMoved_q & ~cmpInhibit_q[1] & (counter_q == cmpTarget[1]);
   // Trigger pin restarts the counter in one-pulse mode and is dead in PWM
   assign trigEvent = pinEdge[0] & (mode_q == MODE_ONE_PULSE);
   assign capOneNormal = pinEdge[0] & (mode_q == MODE_NORMAL);
   assign pwmReload = cmpMatch[1] & (mode_q == MODE_PWM);
   assign cntReload = cntLoWr | trigEvent | pwmReload;
   // Flag sources per mode
   assign cmpSet[0] = cmpMatch[0] & (mode_q == MODE_NORMAL);
   assign cmpSet[1] = cmpMatch[1] & (mode_q != MODE_PWM);
   assign capSet[0] = capOneNormal | trigEvent | pwmReload;
   assign capSet[1] = pinEdge[1];
   // Two-step clear: status read armed the flag, low byte access finishes it
   assign cmpClr = cmpArm_q & cmpLoAcc;
   assign capClr = capArm_q & capLoAcc;

   // Counter; reload covers software write, trigger and PWM period end
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         counter_q <= CNT_RELOAD;
         counterMoved_q <= 1'b0;
      end else begin
         counter_q <= cntReload ? CNT_RELOAD : (tick ? counter_q + 16'h1 : counter_q);
         counterMoved_q <= tick & ~cntReload;
      end
   end

   // Per channel values, flags and arming; a set beats a clear
   generate
      for (genvar ch = 0; ch < 2; ch++) begin : gChan
         always_ff @(posedge clk) begin
            if (!rst_n) begin
               cmpVal_q[ch] <= CMP_RESET;
               capVal_q[ch] <= CAP_RESET;
               cmpInhibit_q[ch] <= 1'b0;
               cmpFlag_q[ch] <= 1'b0;
               capFlag_q[ch] <= 1'b0;
               cmpArm_q[ch] <= 1'b0;
               capArm_q[ch] <= 1'b0;
            end else begin
               if (cmpHiWr[ch]) cmpVal_q[ch][15:8] <= pwdata[7:0];
               if (cmpLoWr[ch]) cmpVal_q[ch][7:0] <= pwdata[7:0];
               cmpInhibit_q[ch] <= cmpHiWr[ch] | (cmpInhibit_q[ch] & ~cmpLoWr[ch]);
               if (ch == 0 && trigEvent) capVal_q[ch] <= CAP_ONE_PULSE_VALUE;
               else if ((ch == 0) ? capOneNormal : capSet[ch]) capVal_q[ch] <= counter_q;
               cmpFlag_q[ch] <= cmpSet[ch] | (cmpFlag_q[ch] & ~cmpClr[ch]);
               capFlag_q[ch] <= capSet[ch] | (capFlag_q[ch] & ~capClr[ch]);
               cmpArm_q[ch] <= (statusRd & cmpFlag_q[ch]) | (cmpArm_q[ch] & ~cmpLoAcc[ch]);
               capArm_q[ch] <= (statusRd & capFlag_q[ch]) | (capArm_q[ch] & ~capLoAcc[ch]);
            end
         end
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   // Waveform pins; a disabled pin keeps its latch untouched
   logic [1:0] pinEn, pinLoad, pinValue, forceOn;
   logic levelOne, levelTwo;
   assign pinEn = {ctrlTwo_q[BIT_PIN_EN2], ctrlTwo_q[BIT_PIN_EN1]};
   assign levelOne = ctrlOne_q[BIT_LEVEL1];
   assign levelTwo = ctrlOne_q[BIT_LEVEL2];
   // Force works only in plain compare mode and sets no flag
   assign forceOn = {ctrlOne_q[BIT_FORCE2], ctrlOne_q[BIT_FORCE1]} & {2{mode_q == MODE_NORMAL}};
   // Pin 1: trigger or period end outranks a width match in the same cycle
   assign pinLoad[0] = pinEn[0] & (cmpMatch[0] | forceOn[0] | trigEvent | pwmReload);
   assign pinValue[0] = (trigEvent | pwmReload) ? levelTwo : levelOne;
   // Pin 2 is only a compare output in plain mode
   assign pinLoad[1] = pinEn[1] & (mode_q == MODE_NORMAL) & (cmpMatch[1] | forceOn[1]);
   assign pinValue[1] = levelTwo;

   always_ff @(posedge clk) begin
      if (!rst_n) pinLevel_q <= 2'b00;
      else pinLevel_q <= (pinLoad & pinValue) | (~pinLoad & pinLevel_q);
   end

   ////////////////////////////////////////////////////////////////////////////
   // Shared timer interrupt; mask gating is registered to keep the pin clean
   always_ff @(posedge clk) begin
      if (!rst_n) irq_q <= 1'b0;
      else irq_q <= ~cpuIrqMask & ((ctrlOne_q[BIT_CMP_IRQ_EN] & |cmpFlag_q) |
                                   (ctrlOne_q[BIT_CAP_IRQ_EN] & |capFlag_q));
   end

   assign prdata = prdata_q;
   assign pready = pready_q;
   assign pslverr = pslverr_q;
   assign compareOutputPin = pinLevel_q;
   assign compareOutputEn = {ctrlTwo_q[BIT_PIN_EN2], ctrlTwo_q[BIT_PIN_EN1]};
   assign timerIrq = irq_q;

   ////////////////////////////////////////////////////////////////////////////
   // Checks
   sequence seqPulseStart;
      counter_q == CNT_RELOAD && capVal_q[0] == CAP_ONE_PULSE_VALUE && capFlag_q[0];
   endsequence
   sequence seqPwmEnd;
      counter_q == CNT_RELOAD && capFlag_q[0] && !cmpFlag_q[1];
   endsequence

   AST_PIN_RESET: assert property (@(posedge clk) disable iff (!rst_n)
      $rose(rst_n) |-> compareOutputPin == 2'b00) else $error("Compare pins not low after reset");
   AST_MATCH_FLAG: assert property (@(posedge clk) disable iff (!rst_n)
      cmpMatch[0] && mode_q == MODE_NORMAL && pinEn[0] |=> cmpFlag_q[0] && compareOutputPin[0] == $past(levelOne))
      else $error("Compare match did not set flag and pin");
   AST_IRQ_MASK: assert property (@(posedge clk) disable iff (!rst_n)
      cpuIrqMask |=> !timerIrq) else $error("Interrupt raised while masked");
   AST_FLAG_CLEAR: assert property (@(posedge clk) disable iff (!rst_n)
      cmpArm_q[0] && cmpLoAcc[0] && !cmpSet[0] |=> !cmpFlag_q[0]) else $error("Compare flag not cleared");
   AST_INHIBIT: assert property (@(posedge clk) disable iff (!rst_n)
      cmpHiWr[1] |=> !cmpMatch[1] until_with cmpLoWr[1]) else $error("Match while compare inhibited");
   AST_INHIBIT_END: assert property (@(posedge clk) disable iff (!rst_n)
      cmpLoWr[1] |=> !cmpInhibit_q[1]) else $error("Inhibit not lifted by low write");
   AST_PIN_DISABLED: assert property (@(posedge clk) disable iff (!rst_n)
      !pinEn[0] |=> $stable(compareOutputPin[0])) else $error("Disabled pin changed");
   AST_TARGET: assert property (@(posedge clk) disable iff (!rst_n)
      counterMoved_q && !cmpInhibit_q[0] && !div2Clk && counter_q == cmpVal_q[0] + 16'h1 |-> cmpMatch[0])
      else $error("Divided clock match not one count late");
   AST_FORCE_NOFLAG: assert property (@(posedge clk) disable iff (!rst_n)
      forceOn[0] && !cmpMatch[0] && !cmpFlag_q[0] |=> !cmpFlag_q[0]) else $error("Force set compare flag");
   AST_FORCE_MODE: assert property (@(posedge clk) disable iff (!rst_n)
      mode_q != MODE_NORMAL |=> $stable(compareOutputPin[1])) else $error("Pin 2 moved outside plain mode");
   AST_TRIGGER: assert property (@(posedge clk) disable iff (!rst_n)
      trigEvent && pinEn[0] |=> seqPulseStart ##0 compareOutputPin[0] == $past(levelTwo))
      else $error("One-pulse start wrong");
   AST_OPM_NO_FLAG1: assert property (@(posedge clk) disable iff (!rst_n)
      mode_q == MODE_ONE_PULSE && !cmpFlag_q[0] |=> !cmpFlag_q[0]) else $error("Flag 1 set in one-pulse mode");
   AST_PWM_PERIOD: assert property (@(posedge clk) disable iff (!rst_n)
      pwmReload && !cmpFlag_q[1] |=> seqPwmEnd) else $error("PWM period end wrong");

   // Pulse mode and PWM waveform steps; level 2 outranks level 1 at a reload
   AST_PULSE_END: assert property (@(posedge clk) disable iff (!rst_n)
      mode_q == MODE_ONE_PULSE && cmpMatch[0] && !trigEvent && pinEn[0] |=> compareOutputPin[0] == $past(levelOne))
      else $error("One-pulse end level wrong");
   AST_PWM_WIDTH: assert property (@(posedge clk) disable iff (!rst_n)
      mode_q == MODE_PWM && cmpMatch[0] && !pwmReload && pinEn[0] |=> compareOutputPin[0] == $past(levelOne))
      else $error("PWM width level wrong");
   AST_PWM_PERIOD_LEVEL: assert property (@(posedge clk) disable iff (!rst_n)
      pwmReload && pinEn[0] |=> compareOutputPin[0] == $past(levelTwo))
      else $error("PWM period level wrong");
   AST_OPM_RESTART: assert property (@(posedge clk) disable iff (!rst_n)
      mode_q == MODE_ONE_PULSE && pinEdge[0] |=> counter_q == CNT_RELOAD && capVal_q[0] == CAP_ONE_PULSE_VALUE)
      else $error("Trigger edge did not restart counter");
   AST_PWM_TRIG_DEAD: assert property (@(posedge clk) disable iff (!rst_n)
      mode_q == MODE_PWM && pinEdge[0] |=> $stable(capVal_q[0]))
      else $error("Trigger pin captured in PWM mode");

   // Flags, interrupts and mode bookkeeping
   AST_PWM_NO_CMP_FLAG: assert property (@(posedge clk) disable iff (!rst_n)
      mode_q == MODE_PWM && cmpFlag_q == 2'b00 |=> cmpFlag_q == 2'b00)
      else $error("Compare flag set in PWM mode");
   AST_OPM_FLAG2: assert property (@(posedge clk) disable iff (!rst_n)
      mode_q == MODE_ONE_PULSE && cmpMatch[1] |=> cmpFlag_q[1])
      else $error("Compare 2 flag missing in one-pulse mode");
   AST_CAP_CLEAR: assert property (@(posedge clk) disable iff (!rst_n)
      capArm_q[0] && capLoAcc[0] && !capSet[0] |=> !capFlag_q[0])
      else $error("Capture flag not cleared");
   AST_CAP_IRQ: assert property (@(posedge clk) disable iff (!rst_n)
      !cpuIrqMask && ctrlOne_q[BIT_CAP_IRQ_EN] && capFlag_q[0] |=> timerIrq)
      else $error("Capture flag did not interrupt");
   AST_CMP_IRQ: assert property (@(posedge clk) disable iff (!rst_n)
      !cpuIrqMask && ctrlOne_q[BIT_CMP_IRQ_EN] && cmpFlag_q[0] |=> timerIrq)
      else $error("Compare flag did not interrupt");
   AST_CMP_HOLD: assert property (@(posedge clk) disable iff (!rst_n)
      !cmpHiWr[0] && !cmpLoWr[0] |=> $stable(cmpVal_q[0]))
      else $error("Compare value changed without a write");
   AST_MODE_TICK: assert property (@(posedge clk) disable iff (!rst_n)
      !tick |=> $stable(mode_q))
      else $error("Mode changed between timer ticks");
   AST_PWM_WINS: assert property (@(posedge clk) disable iff (!rst_n)
      tick && ctrlTwo_q[BIT_PWM] |=> mode_q == MODE_PWM)
      else $error("PWM select did not win");
endmodule

// ---- verilog/tcp_pkg.sv ----
package tcp_pkg;
   // Register byte addresses, one aligned word each
   localparam logic [7:0] ADDR_CTRL_ONE = 8'h00;
   localparam logic [7:0] ADDR_CTRL_TWO = 8'h04;
   localparam logic [7:0] ADDR_STATUS = 8'h08;
   localparam logic [7:0] ADDR_CAP1_HI = 8'h0c;
   localparam logic [7:0] ADDR_CAP1_LO = 8'h10;
   localparam logic [7:0] ADDR_CMP1_HI = 8'h14;
   localparam logic [7:0] ADDR_CMP1_LO = 8'h18;
   localparam logic [7:0] ADDR_CNT_HI = 8'h1c;
   localparam logic [7:0] ADDR_CNT_LO = 8'h20;
   localparam logic [7:0] ADDR_CAP2_HI = 8'h24;
   localparam logic [7:0] ADDR_CAP2_LO = 8'h28;
   localparam logic [7:0] ADDR_CMP2_HI = 8'h2c;
   localparam logic [7:0] ADDR_CMP2_LO = 8'h30;

   // Control one fields
   localparam int BIT_CAP_IRQ_EN = 7;
   localparam int BIT_CMP_IRQ_EN = 6;
   localparam int BIT_FORCE2 = 4;
   localparam int BIT_FORCE1 = 3;
   localparam int BIT_LEVEL2 = 2;
   localparam int BIT_EDGE1 = 1;
   localparam int BIT_LEVEL1 = 0;
   // Control two fields
   localparam int BIT_PIN_EN1 = 7;
   localparam int BIT_PIN_EN2 = 6;
   localparam int BIT_ONE_PULSE = 5;
   localparam int BIT_PWM = 4;
   localparam int BIT_CLK_SEL_HI = 3;
   localparam int BIT_CLK_SEL_LO = 2;
   localparam int BIT_EDGE2 = 1;
   localparam int BIT_EXT_EDGE = 0;
   // Status fields
   localparam int BIT_CAP_FLAG1 = 7;
   localparam int BIT_CMP_FLAG1 = 6;
   localparam int BIT_CAP_FLAG2 = 4;
   localparam int BIT_CMP_FLAG2 = 3;

   // Reset and reload values
   localparam logic [7:0] CTRL_RESET = 8'h00;
   localparam logic [15:0] CNT_RELOAD = 16'hfffc;
   localparam logic [15:0] CAP_ONE_PULSE_VALUE = 16'hfffd;
   localparam logic [15:0] CMP_RESET = 16'h8000;
   localparam logic [15:0] CAP_RESET = 16'h0000;

   // Timer clock selection codes
   localparam logic [1:0] CLK_DIV4 = 2'b00;
   localparam logic [1:0] CLK_DIV2 = 2'b01;
   localparam logic [1:0] CLK_DIV8 = 2'b10;
   localparam logic [1:0] CLK_EXT = 2'b11;

   typedef enum logic [1:0] {
      MODE_NORMAL = 2'b00,
      MODE_ONE_PULSE = 2'b01,
      MODE_PWM = 2'b10
   } tcp_mode_type;
endpackage

// ---- verilog/tcp_timer_tick.sv ----
`timescale 1ns/1ps
module tcp_timer_tick (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [1:0] timerClockSelect,
   input wire logic extEdgeSel,
   input wire logic extClockPin,
   output logic tick
);
   import tcp_pkg::*;

   logic [2:0] div_q;
   logic extSync1_q, extSync2_q, extPrev_q, tick_q;
   logic [2:0] divMask;
   logic extEdge, tick_d;

   ////////////////////////////////////////////////////////////////////////////
   // Prescaler masks: a tick once all selected divider bits are high
   assign divMask = (timerClockSelect == CLK_DIV2) ? 3'h1 :
                    (timerClockSelect == CLK_DIV4) ? 3'h3 : 3'h7;
   // External edge only counts once it has crossed two flops
   assign extEdge = extEdgeSel ? (extSync2_q & ~extPrev_q) : (~extSync2_q & extPrev_q);
   assign tick_d = (timerClockSelect == CLK_EXT) ? extEdge : ((div_q & divMask) == divMask);
   assign tick = tick_q;

   // Free divider and external clock synchroniser
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         div_q <= 3'h0;
         extSync1_q <= 1'b0;
         extSync2_q <= 1'b0;
         extPrev_q <= 1'b0;
         tick_q <= 1'b0;
      end else begin
         div_q <= div_q + 3'h1;
         extSync1_q <= extClockPin;
         extSync2_q <= extSync1_q;
         extPrev_q <= extSync2_q;
         tick_q <= tick_d;
      end
   end
endmodule

// ---- sim/tcp_pin_model.sv ----
`timescale 1ns/1ps
// Far side of the timer pins: trigger and capture sources, waveform watcher
module tcp_pin_model (
   input wire logic clk,
   input wire logic [1:0] compareOutputPin,
   output logic triggerInputPin,
   output logic captureTwoPin,
   output logic extClockPin
);
   int risingCount;
   logic lastPin;

   ////////////////////////////////////////////////////////////////////////////////
   // Idle levels; external clock stays still since the bench uses internal clocks
   initial begin
      triggerInputPin = 1'b0;
      captureTwoPin = 1'b0;
      extClockPin = 1'b0;
      risingCount = 0;
      lastPin = 1'b0;
   end

   // Pulses held several clocks so the two-flop synchroniser cannot miss them
   task automatic fireTrigger();
      @(posedge clk);
      triggerInputPin <= 1'b1;
      repeat (8) @(posedge clk);
      triggerInputPin <= 1'b0;
   endtask

   task automatic fireCaptureTwo();
      @(posedge clk);
      captureTwoPin <= 1'b1;
      repeat (8) @(posedge clk);
      captureTwoPin <= 1'b0;
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   // Count rising edges of the waveform on compare pin 1
   always @(posedge clk) begin
      lastPin <= compareOutputPin[0];
      if (compareOutputPin[0] === 1'b1 && lastPin === 1'b0) begin
         risingCount <= risingCount + 1;
      end
   end
endmodule

// ---- sim/timer_compare_pulse_pwm_bench.sv ----
`timescale 1ns/1ps
module timer_compare_pulse_pwm_bench;
   import tcp_pkg::*;
   logic clk, rst_n, psel, penable, pwrite, cpuIrqMask, pready, pslverr, timerIrq, errSeen;
   logic triggerInputPin, captureTwoPin, extClockPin;
   logic [7:0] paddr, rd;
   logic [31:0] pwdata, prdata;
   logic [1:0] compareOutputPin, compareOutputEn;
   int err_total, cmp_count, cycles, edgesBefore;

   tcp_timer_compare DUT (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .cpuIrqMask(cpuIrqMask), .triggerInputPin(triggerInputPin), .captureTwoPin(captureTwoPin),
      .extClockPin(extClockPin), .compareOutputPin(compareOutputPin),
      .compareOutputEn(compareOutputEn), .timerIrq(timerIrq));

   tcp_pin_model pins (.clk(clk), .compareOutputPin(compareOutputPin), .triggerInputPin(triggerInputPin),
      .captureTwoPin(captureTwoPin), .extClockPin(extClockPin));

   ////////////////////////////////////////////////////////////////////////////////
   // Clock and hang guard
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         err_total++;
         finish_test();
      end
   end

   task automatic finish_test();
      if (err_total == 0 && cmp_count > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         err_total++;
         $display("Error %s expected %h seen %h", name, exp, seen);
      end
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   // One APB transfer; waits on pready rather than assuming the wait state
   task automatic apb(input logic wr, input logic [7:0] a, input logic [7:0] d);
      int n;
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= {24'h000000, d};
      @(posedge clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      rd = prdata[7:0];
      errSeen = pslverr;
      check("pready", {31'h0, pready}, 32'h1);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      apb(1'b1, a, d);
   endtask

   task automatic rdchk(input string name, input logic [7:0] a, input logic [7:0] exp);
      apb(1'b0, a, 8'h00);
      check(name, {24'h0, rd}, {24'h0, exp});
   endtask

   // Sampled mid-cycle so the edge's updates have landed
   task automatic waitPin(input logic lvl, input int maxc);
      int n;
      n = 0;
      while (compareOutputPin[0] !== lvl && n < maxc) begin
         @(negedge clk);
         n++;
      end
      check("pin1", {31'h0, compareOutputPin[0]}, {31'h0, lvl});
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      rst_n = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h00000000;
      cpuIrqMask = 1'b1;
      err_total = 0;
      cmp_count = 0;
      cycles = 0;
      repeat (10) @(posedge clk);
      check("reset pins", {30'h0, compareOutputPin}, 32'h0);
      rst_n <= 1'b1;
      rdchk("cmp1 hi", ADDR_CMP1_HI, 8'h80);
      rdchk("cmp2 lo", ADDR_CMP2_LO, 8'h00);
      apb(1'b0, 8'hfc, 8'h00);
      check("unmapped err", {31'h0, errSeen}, 32'h1);
      // Plain compare at divide-by-8; high write alone must hold matching off
      wr(ADDR_CTRL_ONE, 8'h41);
      wr(ADDR_CTRL_TWO, 8'h88);
      cpuIrqMask <= 1'b0;
      wr(ADDR_CMP1_HI, 8'h00);
      check("pin enable", {30'h0, compareOutputEn}, 32'h1);
      wr(ADDR_CNT_LO, 8'h00);
      repeat (60) @(posedge clk);
      rdchk("inhibited", ADDR_STATUS, 8'h00);
      wr(ADDR_CMP1_LO, 8'h10);
      wr(ADDR_CNT_LO, 8'h00);
      waitPin(1'b1, 250);
      // Divided clock: pin moves while the counter reads value plus one
      rdchk("match count", ADDR_CNT_LO, 8'h11);
      rdchk("flag1", ADDR_STATUS, 8'h40);
      check("irq", {31'h0, timerIrq}, 32'h1);
      cpuIrqMask <= 1'b1;
      repeat (3) @(posedge clk);
      check("masked irq", {31'h0, timerIrq}, 32'h0);
      cpuIrqMask <= 1'b0;
      rdchk("low byte", ADDR_CMP1_LO, 8'h10);
      rdchk("cleared", ADDR_STATUS, 8'h00);
      // Forced level: no flag, no request
      wr(ADDR_CTRL_ONE, 8'h48);
      waitPin(1'b0, 20);
      rdchk("force flag", ADDR_STATUS, 8'h00);
      check("force irq", {31'h0, timerIrq}, 32'h0);
      // One pulse with the force bit left set, which must be ignored
      wr(ADDR_CTRL_ONE, 8'h8e);
      wr(ADDR_CMP1_HI, 8'h00);
      wr(ADDR_CTRL_TWO, 8'ha4);
      wr(ADDR_CMP1_LO, 8'h20);
      repeat (4) @(posedge clk);
      pins.fireTrigger();
      waitPin(1'b1, 30);
      rdchk("cap1 hi", ADDR_CAP1_HI, 8'hff);
      rdchk("cap1 lo", ADDR_CAP1_LO, 8'hfd);
      waitPin(1'b0, 200);
      rdchk("pulse status", ADDR_STATUS, 8'h80);
      check("pulse irq", {31'h0, timerIrq}, 32'h1);
      rdchk("cap1 clear", ADDR_CAP1_LO, 8'hfd);
      rdchk("cap cleared", ADDR_STATUS, 8'h00);
      // PWM with both mode bits set; compare 2 stays inhibited across the switch
      wr(ADDR_CTRL_ONE, 8'h81);
      wr(ADDR_CMP2_HI, 8'h00);
      wr(ADDR_CMP1_LO, 8'h10);
      wr(ADDR_CTRL_TWO, 8'hb4);
      wr(ADDR_CNT_LO, 8'h00);
      wr(ADDR_CMP2_LO, 8'h30);
      edgesBefore = pins.risingCount;
      repeat (600) @(posedge clk);
      check("pwm cycles", {31'h0, (pins.risingCount - edgesBefore) >= 4}, 32'h1);
      pins.fireCaptureTwo();
      repeat (6) @(posedge clk);
      rdchk("pwm status", ADDR_STATUS, 8'h90);
      check("pwm irq", {31'h0, timerIrq}, 32'h1);
      finish_test();
   end
endmodule
